// ### verilog/fsis_pkg.sv
// Package of constants and types for the fail-safe state and integrity register
package fsis_pkg;

  // ****************************************************************
  // Register layout
  // ****************************************************************
  localparam int unsigned REG_WIDTH        = 24;
  localparam int unsigned DEBUG_EXIT_BIT   = 22;
  localparam int unsigned DEBUG_MODE_BIT   = 21;
  localparam int unsigned CONFIG_CORR_BIT  = 19;
  localparam int unsigned INIT_CORR_BIT    = 16;
  localparam int unsigned STATE_CODE_LSB   = 8;
  localparam int unsigned STATE_CODE_WIDTH = 5;
  localparam logic [STATE_CODE_WIDTH-1:0] FAILSAFE_INIT_STATE = 5'h06;

  // ****************************************************************
  // Protected init registers
  // ****************************************************************
  localparam int unsigned INIT_REG_COUNT = 8;
  localparam int unsigned INIT_REG_WIDTH = 8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLOCK_HZ          = 20_000_000;
  localparam int unsigned CHECK_PERIOD_MS   = 5;
  localparam int unsigned CHECK_CYCLES_FULL = CHECK_PERIOD_MS * (CLOCK_HZ / 1000);
  localparam int unsigned PERIOD_CNT_WIDTH  = 17;
  localparam logic [PERIOD_CNT_WIDTH-1:0] PERIOD_CNT_ZERO = 17'h00000;
  localparam logic [PERIOD_CNT_WIDTH-1:0] PERIOD_CNT_ONE  = 17'h00001;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [INIT_REG_WIDTH-1:0] fsis_init_word_t;
  typedef fsis_init_word_t [INIT_REG_COUNT-1:0] fsis_init_bank_t;

  typedef struct packed {
    logic                  write;
    logic [REG_WIDTH-1:0]  data;
  } fsis_reg_write_t;

  typedef struct packed {
    logic                  done;
    logic                  mismatch;
  } fsis_crc_result_t;

  typedef struct packed {
    logic                        debugMode;
    logic                        configCorrupt;
    logic                        initCorrupt;
    logic [PERIOD_CNT_WIDTH-1:0] periodCount;
    logic                        checkStart;
    logic [REG_WIDTH-1:0]        readData;
  } fsis_state_t;

endpackage

// ### verilog/fsis_status_reg.sv
// Fail-safe state and integrity status/control register
// How it works
// - Restart configuration CRC check every 5 ms
// - CRC mismatch sets config corruption bit 19
// - Corruption flags clear on reset or write-1
// - Init registers compared continuously, flag bit 16
// - True copy not complement of shadow sets flag
// - State code in bits 12:8, init 0x06
// - Debug bit 21 and state field live
`timescale 1ns/1ns
module fsis_status_reg
  import fsis_pkg::*;
#(
  parameter int unsigned CHECK_CYCLES = fsis_pkg::CHECK_CYCLES_FULL
) (
  input  wire logic                                       clock,
  input  wire logic                                       nrst,
  input  wire fsis_pkg::fsis_reg_write_t                  regWrite,
  output logic [fsis_pkg::REG_WIDTH-1:0]                  readData,
  input  wire logic                                       debugEnter,
  input  wire logic [fsis_pkg::STATE_CODE_WIDTH-1:0]      failsafeStateCode,
  output logic                                            debugModeStatus,
  output logic                                            crcCheckStart,
  input  wire fsis_pkg::fsis_crc_result_t                 crcResult,
  input  wire fsis_pkg::fsis_init_bank_t                  initTrueCopy,
  input  wire fsis_pkg::fsis_init_bank_t                  initComplementCopy
);
  import fsis_pkg::*;

  // ****************************************************************
  // Init register comparison
  // ****************************************************************
  logic [INIT_REG_COUNT-1:0] initMismatch;
  logic                      anyInitMismatch;

  for (genvar i = 0; i < INIT_REG_COUNT; i++) begin : g_cmp
    // Pure combinational compare so a bad word is seen in the same cycle
    assign initMismatch[i] = (initTrueCopy[i] != ~initComplementCopy[i]);
  end
  assign anyInitMismatch = |initMismatch;

  // ****************************************************************
  // Next state
  // ****************************************************************
  localparam logic [PERIOD_CNT_WIDTH-1:0] PERIOD_RELOAD = PERIOD_CNT_WIDTH'(CHECK_CYCLES - 1);

  fsis_state_t state;
  fsis_state_t next_state;
  logic        exitReq;
  logic        clrConfig;
  logic        clrInit;

  assign exitReq   = regWrite.write && regWrite.data[DEBUG_EXIT_BIT];
  assign clrConfig = regWrite.write && regWrite.data[CONFIG_CORR_BIT];
  assign clrInit   = regWrite.write && regWrite.data[INIT_CORR_BIT];

  always_comb begin
    next_state = state;
    // Periodic restart of the configuration check
    if (state.periodCount == PERIOD_CNT_ZERO) begin
      next_state.periodCount = PERIOD_RELOAD;
      next_state.checkStart  = 1'b1;
    end else begin
      next_state.periodCount = state.periodCount - PERIOD_CNT_ONE;
      next_state.checkStart  = 1'b0;
    end
    // Set wins over a simultaneous write-1 clear
    if (crcResult.done && crcResult.mismatch) begin
      next_state.configCorrupt = 1'b1;
    end else if (clrConfig) begin
      next_state.configCorrupt = 1'b0;
    end
    if (anyInitMismatch) begin
      next_state.initCorrupt = 1'b1;
    end else if (clrInit) begin
      next_state.initCorrupt = 1'b0;
    end
    // Exit request beats a new entry in the same cycle
    if (exitReq) begin
      next_state.debugMode = 1'b0;
    end else if (debugEnter) begin
      next_state.debugMode = 1'b1;
    end
    // Readback, reserved bits zero; live fields sampled every cycle
    next_state.readData = '0;
    next_state.readData[DEBUG_MODE_BIT]  = state.debugMode;
    next_state.readData[CONFIG_CORR_BIT] = state.configCorrupt;
    next_state.readData[INIT_CORR_BIT]   = state.initCorrupt;
    next_state.readData[STATE_CODE_LSB +: STATE_CODE_WIDTH] = failsafeStateCode;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state               <= '0;
      state.periodCount   <= PERIOD_RELOAD;
      state.readData[STATE_CODE_LSB +: STATE_CODE_WIDTH] <= FAILSAFE_INIT_STATE;
    end else begin
      state <= next_state;
    end
  end

  assign readData        = state.readData;
  assign debugModeStatus = state.debugMode;
  assign crcCheckStart   = state.checkStart;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  int unsigned startGap;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      startGap <= 0;
    end else if (state.checkStart) begin
      startGap <= 1;
    end else if (startGap != 0) begin
      startGap <= startGap + 1;
    end
  end

  sequence s_mismatch_seen;
    crcResult.done && crcResult.mismatch;
  endsequence

  sequence s_flag_reported;
    ##1 state.configCorrupt ##1 readData[CONFIG_CORR_BIT];
  endsequence

  a_period_exact: assert property (@(posedge clock) disable iff (!nrst)
    state.checkStart && startGap != 0 |-> startGap == CHECK_CYCLES)
    else $error("check restart spacing wrong");
  a_start_single: assert property (@(posedge clock) disable iff (!nrst)
    crcCheckStart |=> !crcCheckStart)
    else $error("check start longer than one cycle");
  a_config_set: assert property (@(posedge clock) disable iff (!nrst)
    s_mismatch_seen |-> s_flag_reported)
    else $error("config corruption not reported");
  a_config_hold: assert property (@(posedge clock) disable iff (!nrst)
    state.configCorrupt && !clrConfig |=> state.configCorrupt)
    else $error("config flag dropped without write-1");
  a_init_clear: assert property (@(posedge clock) disable iff (!nrst)
    clrInit && !anyInitMismatch |=> !state.initCorrupt)
    else $error("init flag not cleared by write-1");
  a_init_set: assert property (@(posedge clock) disable iff (!nrst)
    anyInitMismatch |=> state.initCorrupt ##1 readData[INIT_CORR_BIT])
    else $error("init corruption not reported");
  a_init_clean: assert property (@(posedge clock) disable iff (!nrst)
    $rose(state.initCorrupt) |-> $past(anyInitMismatch))
    else $error("init flag set without mismatch");
  a_state_live: assert property (@(posedge clock) disable iff (!nrst)
    ##1 readData[STATE_CODE_LSB +: STATE_CODE_WIDTH] == $past(failsafeStateCode))
    else $error("state code readback not live");
  a_debug_read: assert property (@(posedge clock) disable iff (!nrst)
    ##1 readData[DEBUG_MODE_BIT] == $past(debugModeStatus))
    else $error("debug readback wrong");
  a_debug_exit: assert property (@(posedge clock) disable iff (!nrst)
    exitReq |=> !debugModeStatus ##1 !readData[DEBUG_MODE_BIT])
    else $error("debug exit not taken");

  // ****************************************************************
  // Clearing and readback guards
  // ****************************************************************
  // Only these bits may read as one; a stray bit would look like a new fault
  localparam logic [REG_WIDTH-1:0] READ_MASK =
    (REG_WIDTH'(1) << DEBUG_MODE_BIT) |
    (REG_WIDTH'(1) << CONFIG_CORR_BIT) |
    (REG_WIDTH'(1) << INIT_CORR_BIT) |
    (REG_WIDTH'((1 << STATE_CODE_WIDTH) - 1) << STATE_CODE_LSB);

  sequence s_config_clear_seen;
    clrConfig && !(crcResult.done && crcResult.mismatch);
  endsequence

  sequence s_config_dropped;
    ##1 !state.configCorrupt ##1 !readData[CONFIG_CORR_BIT];
  endsequence

  sequence s_init_clear_seen;
    clrInit && !anyInitMismatch;
  endsequence

  sequence s_init_dropped;
    ##1 !state.initCorrupt ##1 !readData[INIT_CORR_BIT];
  endsequence

  a_config_clear: assert property (@(posedge clock) disable iff (!nrst)
    s_config_clear_seen |-> s_config_dropped)
    else $error("config flag not cleared by write-1");
  a_config_cause: assert property (@(posedge clock) disable iff (!nrst)
    $rose(state.configCorrupt) |-> $past(crcResult.done) && $past(crcResult.mismatch))
    else $error("config flag set without mismatch");
  a_config_read: assert property (@(posedge clock) disable iff (!nrst)
    ##1 readData[CONFIG_CORR_BIT] == $past(state.configCorrupt))
    else $error("config readback wrong");
  a_init_drop: assert property (@(posedge clock) disable iff (!nrst)
    s_init_clear_seen |-> s_init_dropped)
    else $error("init flag readback not cleared");
  a_init_hold: assert property (@(posedge clock) disable iff (!nrst)
    state.initCorrupt && !clrInit |=> state.initCorrupt)
    else $error("init flag dropped without write-1");
  a_init_read: assert property (@(posedge clock) disable iff (!nrst)
    ##1 readData[INIT_CORR_BIT] == $past(state.initCorrupt))
    else $error("init readback wrong");
  a_debug_enter: assert property (@(posedge clock) disable iff (!nrst)
    debugEnter && !exitReq |=> debugModeStatus)
    else $error("debug entry not taken");
  a_debug_cause: assert property (@(posedge clock) disable iff (!nrst)
    $rose(debugModeStatus) |-> $past(debugEnter))
    else $error("debug set without entry");
  a_debug_hold: assert property (@(posedge clock) disable iff (!nrst)
    debugModeStatus && !exitReq |=> debugModeStatus)
    else $error("debug left without exit write");
  a_reserved_zero: assert property (@(posedge clock) disable iff (!nrst)
    (readData & ~READ_MASK) == '0)
    else $error("reserved readback bit set");
  a_start_bound: assert property (@(posedge clock) disable iff (!nrst)
    startGap <= CHECK_CYCLES)
    else $error("check restart overdue");

endmodule // fsis_status_reg

// ### tb/fsis_crc_model.sv
// Behavioural CRC engine answering each check start a few cycles later
`timescale 1ns/1ns
module fsis_crc_model
  import fsis_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic                     crcCheckStart,
  input  wire logic                     badCrc,
  output fsis_pkg::fsis_crc_result_t    crcResult
);
  import fsis_pkg::*;
  logic [2:0] delay;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      delay     <= 3'h0;
      crcResult <= '0;
    end else begin
      delay              <= {delay[1:0], crcCheckStart};
      crcResult.done     <= delay[2];
      // Outside done the flag carries the inverse of badCrc so a stale value never passes
      crcResult.mismatch <= delay[2] ? badCrc : ~badCrc;
    end
  end
endmodule // fsis_crc_model

// ### tb/fsis_status_reg_tb.sv
// Self-checking bench for the fail-safe state and integrity register
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module fsis_status_reg_tb;
  import fsis_pkg::*;
  logic clock = 0, nrst = 0, debugEnter = 0, crcCheckStart, debugModeStatus, badCrc = 0;
  fsis_reg_write_t    regWrite = '0;
  logic [23:0]        readData;
  logic [4:0]         failsafeStateCode = 5'h06;
  fsis_crc_result_t   crcResult;
  fsis_init_bank_t    initTrueCopy = {8{8'hA5}}, initComplementCopy = {8{8'h5A}};
  int error_cnt = 0, compares = 0, n;
  localparam int unsigned CHECK_LEN = 16;
  always #25 clock = ~clock;
  fsis_status_reg #(.CHECK_CYCLES(CHECK_LEN)) fsis_status_reg_inst (.clock(clock), .nrst(nrst),
    .regWrite(regWrite), .readData(readData), .debugEnter(debugEnter),
    .failsafeStateCode(failsafeStateCode), .debugModeStatus(debugModeStatus),
    .crcCheckStart(crcCheckStart), .crcResult(crcResult), .initTrueCopy(initTrueCopy),
    .initComplementCopy(initComplementCopy));
  fsis_crc_model fsis_crc_model_inst (.clock(clock), .nrst(nrst),
    .crcCheckStart(crcCheckStart), .badCrc(badCrc), .crcResult(crcResult));
  task automatic step(int k); repeat (k) @(negedge clock); endtask
  task automatic wr(logic [23:0] d);
    regWrite = '{1'b1, d};
    step(1);
    regWrite = '0;
    step(1);
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_state;
    failsafeStateCode = 5'h1F;
    step(1);
    `CHK("state", 24'h001F00, readData)
    failsafeStateCode = 5'h06;
    step(1);
  endtask
  task automatic t_debug;
    debugEnter = 1;
    step(1);
    debugEnter = 0;
    `CHK("dbg status", 1'b1, debugModeStatus)
    step(1);
    `CHK("dbg on", 1'b1, readData[21])
    wr(24'h000000);
    `CHK("dbg w0", 1'b1, debugModeStatus)
    debugEnter = 1;
    regWrite = '{1'b1, 24'h400000};
    step(1);
    debugEnter = 0;
    regWrite = '0;
    `CHK("debug_exit_request st", 1'b0, debugModeStatus)
    step(1);
    `CHK("debug_exit_request", 1'b0, readData[21])
  endtask
  task automatic t_period;
    n = 0;
    while (crcCheckStart !== 1'b1 && n < 40) begin step(1); n++; end
    n = 0;
    do begin step(1); n++; end while (crcCheckStart !== 1'b1 && n < 40);
    `CHK("period", CHECK_LEN, n)
  endtask
  task automatic t_crc;
    badCrc = 1;
    n = 0;
    while (readData[19] !== 1'b1 && n < 40) begin step(1); n++; end
    `CHK("crc set", 1'b1, readData[19])
    badCrc = 0;
    step(6);
    wr(24'h000000);
    `CHK("crc w0", 1'b1, readData[19])
    wr(24'h080000);
    step(1);
    `CHK("crc clr", 24'h000600, readData)
    step(20);
    `CHK("crc ok run", 1'b0, readData[19])
  endtask
  task automatic t_init;
    initComplementCopy[3] = 8'h00;
    step(2);
    `CHK("init set", 1'b1, readData[16])
    wr(24'h010000);
    `CHK("init set wins", 1'b1, readData[16])
    initComplementCopy[3] = 8'h5A;
    wr(24'h000000);
    `CHK("init w0", 1'b1, readData[16])
    wr(24'h010000);
    step(1);
    `CHK("init clr", 1'b0, readData[16])
  endtask
  task automatic t_reset;
    debugEnter = 1;
    initComplementCopy[0] = 8'h00;
    step(1);
    debugEnter = 0;
    initComplementCopy[0] = 8'h5A;
    step(1);
    `CHK("pre rst", 24'h210600, readData)
    nrst = 0;
    step(2);
    `CHK("in rst", 24'h000600, readData)
    `CHK("in rst dbg", 1'b0, debugModeStatus)
    `CHK("in rst start", 1'b0, crcCheckStart)
    nrst = 1;
    step(1);
    `CHK("post rst", 24'h000600, readData)
  endtask
  initial begin
    step(6);
    `CHK("reset", 24'h000600, readData)
    nrst = 1;
    step(1);
    t_state();
    t_debug();
    t_period();
    t_crc();
    t_init();
    t_reset();
    final_report();
  end
  initial begin
    #(2000 * 50);
    error_cnt++;
    final_report();
  end
endmodule // fsis_status_reg_tb
